/* logic/swp_monitor_pkg.sv */
// Constants, types and state layout for the switching period window monitor.
package swp_monitor_pkg;
    // System clock period in picoseconds (40 MHz).
    localparam int unsigned CLK_PERIOD_PS = 25000;
    // Blanking window lengths at the slowest and fastest settings, in nanoseconds.
    localparam int unsigned BLANK_SLOW_NS = 450;
    localparam int unsigned BLANK_FAST_NS = 100;
    // Minimum low time of a gate, in nanoseconds, slowest and fastest setting.
    localparam int unsigned MINOFF_SLOW_NS = 300;
    localparam int unsigned MINOFF_FAST_NS = 75;
    // Least times round up to whole cycles.
    localparam int unsigned BLANK_SLOW_CYC  = (BLANK_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned BLANK_FAST_CYC  = (BLANK_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned MINOFF_SLOW_CYC = (MINOFF_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned MINOFF_FAST_CYC = (MINOFF_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Scaling divisors mapping nominal period (cycles) to window lengths.
    localparam int unsigned BLANK_DIV  = 22;
    localparam int unsigned MINOFF_DIV = 33;
    // Long and short period limits as tenths of the nominal period.
    localparam int unsigned LONG_TENTHS  = 13;
    localparam int unsigned SHORT_TENTHS = 7;
    localparam int unsigned TENTHS       = 10;
    // Long-ramp cycles the dummy load stays on once the ramp is above 3 V and pulses stop.
    localparam int unsigned DL_HOLD_CYCLES = 128;
    // Widths.
    localparam int unsigned PSET_W = 16;
    localparam int unsigned CNT_W  = 18;
    localparam int unsigned WIN_W  = 5;
    localparam int unsigned DLC_W  = 8;

    typedef logic [PSET_W-1:0] pset_t;
    typedef logic [CNT_W-1:0]  cnt_t;
    typedef logic [WIN_W-1:0]  win_t;

    // Operating mode of the monitor.
    typedef enum logic [1:0] {
        MODE_LOCKOUT,
        MODE_RUN,
        MODE_FAULT
    } mode_e;

    // Analog status levels presented to the block.
    typedef struct packed {
        logic undervoltage_lockout;   // High while the supply is below lockout.
        logic softstart_above_onset;  // High while the ramp is above its onset level.
        logic softstart_above_3v;     // High while the ramp is above 3 V.
        logic shutdown_sense;         // High while primary shutdown is sensed.
    } analog_s;

    // Gate and housekeeping outputs.
    typedef struct packed {
        logic forward_gate;
        logic freewheel_gate;
        logic softstart_discharge;
        logic dummy_load_sink;
        logic freq_fault;
    } drive_s;

    // Complete state of the monitor.
    typedef struct packed {
        mode_e            mode;
        logic             pwm_prev;
        cnt_t             per_cnt;
        win_t             blank_cnt;
        win_t             low_fwd;
        win_t             low_fw;
        logic             pulse_seen;
        pset_t            tick_cnt;
        logic [DLC_W:0]   dl_cnt;
        drive_s           drv;
    } state_s;
endpackage

/* logic/switching_period_window_monitor.sv */
// Switching period window monitor with gate drive gating and dummy load control.
`timescale 1ns/1ps

module switching_period_window_monitor (
    // Clock and reset.
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Conditioned PWM and programmed nominal period in clock cycles.
    input  wire logic                   pwm_i,
    input  wire swp_monitor_pkg::pset_t period_set_value_i,
    // Analog status levels.
    input  wire swp_monitor_pkg::analog_s analog_i,
    // Gate drives and housekeeping outputs.
    output      swp_monitor_pkg::drive_s  drive_o
);
    import swp_monitor_pkg::*;

    state_s st_r;   // Registered state.
    state_s st_nxt; // Next state.
    cnt_t   long_lim;   // Long-period limit in cycles.
    cnt_t   short_lim;  // Short-period limit in cycles.
    win_t   blank_len;  // Blanking window length in cycles.
    win_t   minoff_win; // Minimum low time inside a window.
    win_t   minoff_len; // Minimum low time in force now.
    logic   rise;       // Rising edge of the conditioned PWM.
    logic   fall;       // Falling edge of the conditioned PWM.
    logic   blank_open; // A blanking window is open.
    logic   gate_en;    // Gates may switch.
    logic   long_hit;   // Long-period limit reached.
    logic   short_hit;  // Rising edge came too early.
    logic   ramp_tick;  // One long-ramp cycle elapsed.

    // Scales a nominal period into a clamped window length.
    function automatic win_t scale_win(input pset_t p, input int unsigned div,
                                       input int unsigned lo, input int unsigned hi);
        int unsigned q;
        q = int'(p) / div;
        if (q < lo) begin
            q = lo;
        end else if (q > hi) begin
            q = hi;
        end
        return win_t'(q);
    endfunction

    // Limits and windows all derive from the single programming value.
    always_comb begin
        long_lim   = cnt_t'((int'(period_set_value_i) * LONG_TENTHS) / TENTHS);
        short_lim  = cnt_t'((int'(period_set_value_i) * SHORT_TENTHS) / TENTHS);
        blank_len  = scale_win(period_set_value_i, BLANK_DIV, BLANK_FAST_CYC, BLANK_SLOW_CYC);
        minoff_win = scale_win(period_set_value_i, MINOFF_DIV, MINOFF_FAST_CYC, MINOFF_SLOW_CYC);
    end

    // Edge detection, window status and fault causes.
    always_comb begin
        rise       = pwm_i & ~st_r.pwm_prev;
        fall       = ~pwm_i & st_r.pwm_prev;
        blank_open = (st_r.blank_cnt != '0);
        minoff_len = blank_open ? minoff_win : win_t'(MINOFF_FAST_CYC);
        long_hit   = (st_r.per_cnt >= long_lim);
        short_hit  = rise & st_r.pulse_seen & ~blank_open & (st_r.per_cnt < short_lim);
        ramp_tick  = (st_r.tick_cnt >= pset_t'(period_set_value_i - 16'h0001));
    end

    // Next-state logic for mode, counters and outputs.
    always_comb begin
        st_nxt          = st_r;
        st_nxt.pwm_prev = pwm_i;
        // Period counter restarts on each rising edge and saturates.
        if (rise) begin
            st_nxt.per_cnt = cnt_t'(1);
        end else if (st_r.per_cnt != '1) begin
            st_nxt.per_cnt = st_r.per_cnt + cnt_t'(1);
        end
        // Blanking window opens on either edge.
        if (rise | fall) begin
            st_nxt.blank_cnt = blank_len;
        end else if (blank_open) begin
            st_nxt.blank_cnt = st_r.blank_cnt - win_t'(1);
        end
        // Mode sequencing.
        case (st_r.mode)
            MODE_LOCKOUT: begin
                // Leave lockout once the supply is good.
                if (!analog_i.undervoltage_lockout) begin
                    st_nxt.mode = MODE_RUN;
                end
            end
            MODE_RUN: begin
                // After a seen pulse, a long period or an early edge outside blanking trips the fault, as does sensed shutdown.
                if (analog_i.undervoltage_lockout) begin
                    st_nxt.mode = MODE_LOCKOUT;
                end else if ((long_hit & st_r.pulse_seen) | short_hit | analog_i.shutdown_sense) begin
                    st_nxt.mode = MODE_FAULT;
                end
            end
            MODE_FAULT: begin
                // A fresh pulse with good supply begins the restart.
                if (analog_i.undervoltage_lockout) begin
                    st_nxt.mode = MODE_LOCKOUT;
                end else if (rise & ~analog_i.shutdown_sense) begin
                    st_nxt.mode = MODE_RUN;
                end
            end
            default: begin
                st_nxt.mode = MODE_LOCKOUT;
            end
        endcase
        // A valid pulse is any rising edge seen with good supply, in any mode, fault included.
        if (analog_i.undervoltage_lockout) begin
            st_nxt.pulse_seen = 1'b0;
        end else if (rise) begin
            st_nxt.pulse_seen = 1'b1;
        end
        // Long-ramp cycle ticks, restarted by each rising edge.
        if (rise | ramp_tick) begin
            st_nxt.tick_cnt = '0;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + pset_t'(1);
        end
        // Ramp cycles since last valid pulse, counted only above 3 V.
        if (rise | ~analog_i.softstart_above_3v) begin
            st_nxt.dl_cnt = '0;
        end else if (ramp_tick && st_r.dl_cnt < (DLC_W+1)'(DL_HOLD_CYCLES)) begin
            st_nxt.dl_cnt = st_r.dl_cnt + (DLC_W+1)'(1);
        end
        // Gate enable uses the next mode so fault and low gates coincide.
        gate_en = (st_nxt.mode == MODE_RUN) & analog_i.softstart_above_onset;
        // Minimum low time counters per gate.
        st_nxt.low_fwd = st_r.drv.forward_gate ? '0 :
                         (st_r.low_fwd == '1 ? st_r.low_fwd : st_r.low_fwd + win_t'(1));
        st_nxt.low_fw  = st_r.drv.freewheel_gate ? '0 :
                         (st_r.low_fw == '1 ? st_r.low_fw : st_r.low_fw + win_t'(1));
        // Forward in phase, freewheel in antiphase, each after its low time.
        st_nxt.drv.forward_gate   = gate_en & pwm_i &
                                    (st_r.drv.forward_gate | (st_r.low_fwd >= minoff_len));
        st_nxt.drv.freewheel_gate = gate_en & ~pwm_i &
                                    (st_r.drv.freewheel_gate | (st_r.low_fw >= minoff_len));
        st_nxt.drv.freq_fault          = (st_nxt.mode == MODE_FAULT);
        st_nxt.drv.softstart_discharge = (st_nxt.mode != MODE_RUN);
        // Dummy load sink after lockout, gated by ramp level and pulse history.
        st_nxt.drv.dummy_load_sink = ~analog_i.undervoltage_lockout & st_nxt.pulse_seen &
                                     (~analog_i.softstart_above_3v |
                                      (st_nxt.dl_cnt < (DLC_W+1)'(DL_HOLD_CYCLES)));
    end

    // State register with asynchronous reset.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r      <= '0;
            st_r.mode <= MODE_LOCKOUT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign drive_o = st_r.drv;

    // Checks on the monitor behaviour.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Long period after a seen pulse trips the fault next cycle.
    property p_long_fault;
        (st_r.mode == MODE_RUN) && st_r.pulse_seen && long_hit && !analog_i.undervoltage_lockout
            |=> drive_o.freq_fault;
    endproperty
    a_long_fault: assert property (p_long_fault) else $error("Long period did not trip fault.");

    // Early rising edge outside blanking trips the fault.
    property p_short_fault;
        (st_r.mode == MODE_RUN) && short_hit && !analog_i.undervoltage_lockout |=> drive_o.freq_fault;
    endproperty
    a_short_fault: assert property (p_short_fault) else $error("Short period did not trip fault.");

    // Fault means both gates low and ramp discharged.
    property p_fault_off;
        drive_o.freq_fault |-> !drive_o.forward_gate && !drive_o.freewheel_gate && drive_o.softstart_discharge;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("Gates active during fault.");

    // Fault clears on the cycle after a rising edge with good supply.
    property p_restart;
        drive_o.freq_fault && rise && !analog_i.undervoltage_lockout && !analog_i.shutdown_sense
            |=> !drive_o.freq_fault;
    endproperty
    a_restart: assert property (p_restart) else $error("Fault did not release on pulse.");

    // Every edge opens a blanking window of the scaled length.
    property p_blank_open;
        (rise || fall) |=> (st_r.blank_cnt == $past(blank_len)) && (st_r.blank_cnt >= win_t'(BLANK_FAST_CYC))
            && (st_r.blank_cnt <= win_t'(BLANK_SLOW_CYC));
    endproperty
    a_blank_open: assert property (p_blank_open) else $error("Blanking window not opened.");

    // Inside a window no short fault is raised.
    property p_blank_quiet;
        blank_open && (st_r.mode == MODE_RUN) && !long_hit && !analog_i.shutdown_sense
            && !analog_i.undervoltage_lockout |=> !drive_o.freq_fault;
    endproperty
    a_blank_quiet: assert property (p_blank_quiet) else $error("Fault raised in blanking.");

    // Period counter restarts on a rising edge.
    property p_restart_count;
        rise |=> (st_r.per_cnt == cnt_t'(1));
    endproperty
    a_restart_count: assert property (p_restart_count) else $error("Period count not restarted.");

    // Gates stay low while in lockout.
    property p_lockout;
        analog_i.undervoltage_lockout |=> !drive_o.forward_gate && !drive_o.freewheel_gate;
    endproperty
    a_lockout: assert property (p_lockout) else $error("Gate high in lockout.");

    // Gates never overlap and forward needs PWM high.
    property p_complement;
        drive_o.forward_gate |-> !drive_o.freewheel_gate && $past(pwm_i);
    endproperty
    a_complement: assert property (p_complement) else $error("Gate phasing wrong.");

    // The forward gate, once it falls, stays low for at least the fast minimum low time.
    property p_minoff;
        $fell(drive_o.forward_gate) |-> !drive_o.forward_gate [*3];
    endproperty
    a_minoff: assert property (p_minoff) else $error("Forward low time too short.");

    // The freewheel gate honours the same fast minimum low time after it falls.
    property p_minoff_fw;
        $fell(drive_o.freewheel_gate) |-> !drive_o.freewheel_gate [*3];
    endproperty
    a_minoff_fw: assert property (p_minoff_fw) else $error("Freewheel low time too short.");

    // Ramp below onset holds both gates low.
    property p_onset;
        !analog_i.softstart_above_onset |=> !drive_o.forward_gate && !drive_o.freewheel_gate;
    endproperty
    a_onset: assert property (p_onset) else $error("Gate high below onset.");

    // Dummy load on when ramp low, pulse seen and supply good.
    property p_dl_on;
        !analog_i.undervoltage_lockout && !analog_i.softstart_above_3v && st_r.pulse_seen
            |=> drive_o.dummy_load_sink;
    endproperty
    a_dl_on: assert property (p_dl_on) else $error("Dummy load not active.");

    c_long_fault: cover property ((st_r.mode == MODE_RUN) && st_r.pulse_seen && long_hit);
    c_short_fault: cover property ((st_r.mode == MODE_RUN) && short_hit);
    c_restart: cover property (drive_o.freq_fault ##1 !drive_o.freq_fault);
    c_dl_release: cover property ($fell(drive_o.dummy_load_sink) && analog_i.softstart_above_3v);
endmodule

/* sim/pwm_source.sv */
// Primary-side PWM source model that drives the conditioned PWM level.
`timescale 1ns/1ps
module pwm_source (
    // Clock and run control.
    input  wire logic        clk_i,
    input  wire logic        run_i,
    // Period and high time in clock cycles.
    input  wire logic [15:0] per_i,
    input  wire logic [15:0] hi_i,
    // Conditioned PWM level.
    output logic             pwm_o
);
    logic [15:0] cnt_r = 16'h0000; // Position inside the current period.

    initial pwm_o = 1'b0;

    // Moves on the falling edge only, and rests low while stopped, so a stop is a missing pulse.
    always @(negedge clk_i) begin
        pwm_o <= run_i && (cnt_r < hi_i);
        cnt_r <= (run_i && (cnt_r + 16'h0001) != per_i) ? cnt_r + 16'h0001 : 16'h0000;
    end
endmodule

/* sim/switching_period_window_monitor_test.sv */
// Self-checking bench for the switching period window monitor.
`timescale 1ns/1ps
module switching_period_window_monitor_test;
    import swp_monitor_pkg::*;
    typedef struct { int set; int per; logic flt; } row_s;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        run = 1'b0;        // Lets the PWM source run.
    logic        ovr = 1'b0;        // Hands the PWM line to the bench.
    logic        ovr_pwm = 1'b0;    // PWM level driven by the bench.
    logic        fault_seen = 1'b0; // Set by any fault since last cleared.
    logic [15:0] per = 16'h0064;
    logic [15:0] hi = 16'h0032;
    logic        src_pwm;
    logic        pwm_i;
    pset_t       period_set_value_i = 16'h0064;
    analog_s     analog_i = 4'hC;
    drive_s      drive_o;
    int          failures = 0;
    int          comparisons = 0;
    // Programmed period, actual period, fault expected.
    row_s        rows [8] = '{'{100, 100, 1'b0}, '{100, 125, 1'b0}, '{100, 75, 1'b0}, '{100, 135, 1'b1},
                              '{100, 65, 1'b1}, '{200, 150, 1'b0}, '{200, 270, 1'b1}, '{50, 60, 1'b0}};

    assign pwm_i = ovr ? ovr_pwm : src_pwm;

    // Free-running 40 MHz clock.
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    pwm_source i_src (.clk_i(clk_i), .run_i(run), .per_i(per), .hi_i(hi), .pwm_o(src_pwm));
    switching_period_window_monitor i_dut (.clk_i(clk_i), .rst_i(rst_i), .pwm_i(pwm_i),
        .period_set_value_i(period_set_value_i), .analog_i(analog_i), .drive_o(drive_o));

    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic gates(input logic fwd, input logic fw);
        check_bit(drive_o.forward_gate, fwd);
        check_bit(drive_o.freewheel_gate, fw);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Resets for 20 cycles, then releases with the chosen lockout level.
    task automatic do_reset(input logic uv);
        rst_i = 1'b1;
        run <= 1'b0;
        ovr = 1'b0;
        analog_i = 4'hC;
        period_set_value_i = 16'h0064;
        wait_n(20);
        check_bit(drive_o === '0, 1'b1);
        rst_i = 1'b0;
        analog_i.undervoltage_lockout = uv;
        wait_n(4);
        fault_seen = 1'b0;
    endtask

    // One bench-driven pulse: high for h cycles, then low for l cycles.
    task automatic pulse(input int h, input int l);
        ovr_pwm = 1'b1;
        wait_n(h);
        ovr_pwm = 1'b0;
        wait_n(l);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // A fault must always hold both gates low and discharge the ramp.
    always @(negedge clk_i) begin
        if (drive_o.freq_fault === 1'b1) begin
            fault_seen = 1'b1;
            gates(1'b0, 1'b0);
            check_bit(drive_o.softstart_discharge, 1'b1);
        end
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (60000) @(posedge clk_i);
        failures++;
        give_verdict();
    end

    initial begin
        // Steady periods against several programmed values.
        foreach (rows[i]) begin
            do_reset(1'b0);
            period_set_value_i = 16'(rows[i].set);
            per = 16'(rows[i].per);
            hi = 16'(rows[i].per / 2);
            run <= 1'b1;
            wait_n(7 * rows[i].per + rows[i].per / 4);
            if (!rows[i].flt) begin
                gates(1'b1, 1'b0);
                wait_n(rows[i].per / 2);
                gates(1'b0, 1'b1);
            end
            check_bit(fault_seen, rows[i].flt);
            $display("row %0d done", i);
        end
        // Lockout, ramp onset, missing pulse and restart.
        do_reset(1'b1);
        per = 16'h0064;
        hi = 16'h0032;
        run <= 1'b1;
        wait_n(325);
        gates(1'b0, 1'b0);
        check_bit(drive_o.softstart_discharge, 1'b1);
        check_bit(drive_o.dummy_load_sink, 1'b0);
        analog_i.undervoltage_lockout = 1'b0;
        wait_n(100);
        gates(1'b1, 1'b0);
        check_bit(drive_o.dummy_load_sink, 1'b1);
        analog_i.softstart_above_onset = 1'b0;
        wait_n(100);
        gates(1'b0, 1'b0);
        analog_i.softstart_above_onset = 1'b1;
        run <= 1'b0;
        wait_n(140);
        check_bit(drive_o.freq_fault, 1'b1);
        run <= 1'b1;
        wait_n(25);
        check_bit(drive_o.freq_fault, 1'b0);
        check_bit(drive_o.softstart_discharge, 1'b0);
        gates(1'b1, 1'b0);
        $display("lockout and restart test done");
        // Close rising edges inside the rising and the falling windows.
        run <= 1'b0;
        ovr = 1'b1;
        repeat (3) pulse(50, 50);
        fault_seen = 1'b0;
        pulse(1, 2);
        pulse(47, 50);
        pulse(5, 2);
        pulse(43, 50);
        check_bit(fault_seen, 1'b0);
        $display("blanking test done");
        // Dummy load before and after the ramp passes 3 V.
        do_reset(1'b0);
        ovr = 1'b1;
        check_bit(drive_o.dummy_load_sink, 1'b0);
        repeat (3) pulse(50, 50);
        check_bit(drive_o.dummy_load_sink, 1'b1);
        analog_i.softstart_above_3v = 1'b1;
        pulse(50, 50);
        wait_n(12600);
        check_bit(drive_o.dummy_load_sink, 1'b1);
        wait_n(200);
        check_bit(drive_o.dummy_load_sink, 1'b0);
        $display("dummy load test done");
        // Sensed primary shutdown trips the shared fault; a fresh pulse restarts.
        do_reset(1'b0);
        run <= 1'b1;
        wait_n(150);
        analog_i.shutdown_sense = 1'b1;
        wait_n(2);
        check_bit(drive_o.freq_fault, 1'b1);
        gates(1'b0, 1'b0);
        check_bit(drive_o.softstart_discharge, 1'b1);
        analog_i.shutdown_sense = 1'b0;
        wait_n(60);
        check_bit(drive_o.freq_fault, 1'b0);
        gates(1'b1, 1'b0);
        $display("shutdown test done");
        give_verdict();
    end
endmodule
